/* File: shared/pef_pkg.sv */
// Constants for the power event flag and interrupt pin configuration block
package pef_pkg;
    localparam logic [7:0] ADDR_POWER_CFG      = 8'hc5;
    localparam logic [7:0] ADDR_KEY            = 8'hc1;
    localparam logic [7:0] ADDR_EVENT_ENABLE   = 8'hec;
    localparam logic [7:0] ADDR_PERIPHERAL_CFG_CFG     = 8'hf4;
    localparam logic [7:0] ADDR_BATT_SWITCH    = 8'hf5;
    localparam logic [7:0] ADDR_EVENT_FLAGS    = 8'hf8;
    localparam logic [7:0] ADDR_SCRATCH_ONE    = 8'hfb;
    localparam logic [7:0] ADDR_SCRATCH_TWO    = 8'hfc;
    localparam logic [7:0] ADDR_SCRATCH_THREE  = 8'hfd;
    localparam logic [7:0] ADDR_SCRATCH_FOUR   = 8'hfe;
    localparam logic [7:0] ADDR_IRQ_PIN_CFG    = 8'hff;

    localparam logic [7:0] UNLOCK_KEY          = 8'hea;

    localparam int BIT_SUPPLY_RESTORED = 7;
    localparam int BIT_SUMMARY         = 6;
    localparam int BIT_SAG             = 5;
    localparam int BIT_RESERVED        = 4;
    localparam int BIT_DCIN_MEASURE    = 3;
    localparam int BIT_BATTERY_MON     = 2;
    localparam int BIT_BATTERY_SWITCH  = 1;
    localparam int BIT_DCIN_LOW        = 0;

    // Pin config field positions
    localparam int CAL_SEL_LSB   = 5;
    localparam int IRQ1_FN_LSB   = 1;
    localparam int IRQ0_FN_BIT   = 0;

    // Bits of the flag register that hardware may set (bit 6 and bit 4 excluded)
    localparam logic [7:0] EVENT_MASK    = 8'haf;
    // Writable bits of the pin config register (bits 7 and 4 reserved)
    localparam logic [7:0] PIN_CFG_MASK  = 8'h6f;
    localparam logic [7:0] BATT_SW_MASK  = 8'h03;
    localparam logic [7:0] PERIPHERAL_CFG_MASK   = 8'h0b;

    localparam logic [7:0] RST_ZERO      = 8'h00;
    // Supply source and supply good read as set out of reset
    localparam logic [7:0] RST_PERIPHERAL_CFG    = 8'h60;

    // Calibration windows in seconds and output rates in Hz
    localparam real CAL_WINDOW_LONG_S   = 30.5;
    localparam real CAL_WINDOW_SHORT_S  = 0.244;
    localparam int  CAL_FREQ_SEL0_HZ    = 1;
    localparam int  CAL_FREQ_SEL1_HZ    = 512;
    localparam int  CAL_FREQ_SEL2_HZ    = 500;
    localparam int  CAL_FREQ_SEL3_HZ    = 16384;

    typedef enum logic [3:0] {
        PEF_CAL_1HZ    = 4'b0001,
        PEF_CAL_512HZ  = 4'b0010,
        PEF_CAL_500HZ  = 4'b0100,
        PEF_CAL_16KHZ  = 4'b1000
    } pef_cal_mode_t;
endpackage

/* File: rtl/pef_event_flag.sv */
// One sticky event flag: edge of the event sets it, a zero write clears it
`timescale 1ns/1ps
module pef_event_flag (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic eventIn,
    input  wire logic clearReq,
    output logic      flag
);
    logic evtSync1_r;
    logic evtSync2_r;
    logic evtPrev_r;
    logic evtRise;

    assign evtRise = evtSync2_r & ~evtPrev_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            evtSync1_r <= 1'b0;
            evtSync2_r <= 1'b0;
            evtPrev_r  <= 1'b0;
            flag       <= 1'b0;
        end else begin
            evtSync1_r <= eventIn;
            evtSync2_r <= evtSync1_r;
            evtPrev_r  <= evtSync2_r;
            // Set wins over a clear in the same cycle so no event is dropped
            if (evtRise)
                flag <= 1'b1;
            else if (clearReq)
                flag <= 1'b0;
        end
    end
endmodule

/* File: rtl/pef_power_events.sv */
// Power event flags, event enables and key-protected interrupt pin configuration
`timescale 1ns/1ps
// Function
// - Select 00/01/10/11 gives 1 Hz, 512 Hz (30.5 s) or 500 Hz, 16 kHz (0.244 s), reset 00.
// - The pin configuration register accepts a write only while the key register holds 0xea.
// - Flag bit 7 sets when the switched supply moves from battery back to main supply.
// - Flag bit 6 sets whenever an enabled power event condition occurs.
// - Flag bit 5 sets on a line voltage sag report.
// - Flag bit 3 sets on a DC input change past its threshold or a new DC input measurement.
// - Flag bit 2 sets on battery below threshold or a new battery measurement.
// - Flag bit 1 sets when the switched supply moves from main supply to battery.
// - Flag bit 0 sets when the DC input falls below 1.2 V.
// - Each flag except summary bit 6 has its own enable bit, reset 0, and only enabled flags feed the summary.
module pef_power_events (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic       onMainSupply,
    input  wire logic       sagEvent,
    input  wire logic       dcinDeltaEvent,
    input  wire logic       dcinReadyEvent,
    input  wire logic       battLowEvent,
    input  wire logic       battReadyEvent,
    input  wire logic       dcinLowEvent,
    output logic [7:0]      sfrRdData,
    output logic            sfrHit,
    output logic [3:0]      calOutSel,
    output logic            calWindowLong,
    output logic            extIrq1Enable,
    output logic            extIrq1GpioMode,
    output logic            batteryCtrlInputEn,
    output logic            extIrq0Enable,
    output logic [7:0]      eventFlagsOut,
    output logic            powerEventIrq
);
    logic [7:0] unlockKey_r;
    logic [7:0] irqPinCfg_r;
    logic [7:0] eventEnable_r;
    logic [7:0] powerCfg_r;
    logic [7:0] periphCfg_r;
    logic [7:0] battSwitchCfg_r;
    logic [7:0] scratch_r [4];
    logic       summary_r;
    logic [7:0] flags;
    logic [7:0] flagClear;
    logic [7:0] eventVec;
    logic [7:0] rdMux;
    logic       hitAddr;
    logic       suppSync1_r;
    logic       suppSync2_r;
    logic       suppPrev_r;
    logic       wrFlags;
    logic       wrPinCfg;
    logic       pinCfgUnlocked;
    logic       summarySet;
    logic [2:0] irq1Fn;
    pef_pkg::pef_cal_mode_t calMode;

    function automatic logic wrHit(input logic [7:0] a);
        wrHit = sfrWrEn && (sfrAddr == a);
    endfunction

    // Supply source level sampled once; edges each way feed two flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            suppSync1_r <= 1'b1;
            suppSync2_r <= 1'b1;
            suppPrev_r  <= 1'b1;
        end else begin
            suppSync1_r <= onMainSupply;
            suppSync2_r <= suppSync1_r;
            suppPrev_r  <= suppSync2_r;
        end
    end

    assign eventVec[pef_pkg::BIT_SUPPLY_RESTORED] = suppSync2_r & ~suppPrev_r;
    assign eventVec[pef_pkg::BIT_SUMMARY]         = 1'b0;
    assign eventVec[pef_pkg::BIT_SAG]             = sagEvent;
    assign eventVec[pef_pkg::BIT_RESERVED]        = 1'b0;
    assign eventVec[pef_pkg::BIT_DCIN_MEASURE]    = dcinDeltaEvent | dcinReadyEvent;
    assign eventVec[pef_pkg::BIT_BATTERY_MON]     = battLowEvent | battReadyEvent;
    assign eventVec[pef_pkg::BIT_BATTERY_SWITCH]  = ~suppSync2_r & suppPrev_r;
    assign eventVec[pef_pkg::BIT_DCIN_LOW]        = dcinLowEvent;

    assign wrFlags   = wrHit(pef_pkg::ADDR_EVENT_FLAGS);
    assign flagClear = {8{wrFlags}} & ~sfrWrData;

    // Supply edges are already synchronous pulses; the flag cell resamples them,
    // costing two cycles of latency but keeping one flag cell for all sources
    for (genvar i = 0; i < 8; i++) begin : gFlag
        if (pef_pkg::EVENT_MASK[i]) begin : gLive
            pef_event_flag uFlag (
                .clk      (clk),
                .rstn     (rstn),
                .eventIn  (eventVec[i]),
                .clearReq (flagClear[i]),
                .flag     (flags[i])
            );
        end else if (i == pef_pkg::BIT_SUMMARY) begin : gSum
            assign flags[i] = summary_r;
        end else begin : gZero
            assign flags[i] = 1'b0;
        end
    end

    // Summary raised by any enabled flag; a new level beats a clear
    assign summarySet = |(flags & eventEnable_r & pef_pkg::EVENT_MASK);

    assign pinCfgUnlocked = (unlockKey_r == pef_pkg::UNLOCK_KEY);
    assign wrPinCfg       = wrHit(pef_pkg::ADDR_IRQ_PIN_CFG) && pinCfgUnlocked;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            summary_r <= 1'b0;
        end else if (summarySet) begin
            summary_r <= 1'b1;
        end else if (flagClear[pef_pkg::BIT_SUMMARY]) begin
            summary_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            unlockKey_r     <= pef_pkg::RST_ZERO;
            irqPinCfg_r     <= pef_pkg::RST_ZERO;
            eventEnable_r   <= pef_pkg::RST_ZERO;
            powerCfg_r      <= pef_pkg::RST_ZERO;
            periphCfg_r     <= pef_pkg::RST_ZERO;
            battSwitchCfg_r <= pef_pkg::RST_ZERO;
            for (int k = 0; k < 4; k++)
                scratch_r[k] <= pef_pkg::RST_ZERO;
        end else begin
            if (wrHit(pef_pkg::ADDR_KEY))
                unlockKey_r <= sfrWrData;
            if (wrPinCfg)
                irqPinCfg_r <= sfrWrData & pef_pkg::PIN_CFG_MASK;
            if (wrHit(pef_pkg::ADDR_EVENT_ENABLE))
                eventEnable_r <= sfrWrData & pef_pkg::EVENT_MASK;
            if (wrHit(pef_pkg::ADDR_POWER_CFG))
                powerCfg_r <= sfrWrData;
            if (wrHit(pef_pkg::ADDR_PERIPHERAL_CFG_CFG))
                periphCfg_r <= sfrWrData & pef_pkg::PERIPHERAL_CFG_MASK;
            if (wrHit(pef_pkg::ADDR_BATT_SWITCH))
                battSwitchCfg_r <= sfrWrData & pef_pkg::BATT_SW_MASK;
            if (wrHit(pef_pkg::ADDR_SCRATCH_ONE))
                scratch_r[0] <= sfrWrData;
            if (wrHit(pef_pkg::ADDR_SCRATCH_TWO))
                scratch_r[1] <= sfrWrData;
            if (wrHit(pef_pkg::ADDR_SCRATCH_THREE))
                scratch_r[2] <= sfrWrData;
            if (wrHit(pef_pkg::ADDR_SCRATCH_FOUR))
                scratch_r[3] <= sfrWrData;
        end
    end

    // Pin decode: bit 1 of the field picks battery control, bits 2..3 both set enable
    assign irq1Fn = irqPinCfg_r[pef_pkg::IRQ1_FN_LSB +: 3];
    always_comb begin
        unique case (irqPinCfg_r[pef_pkg::CAL_SEL_LSB +: 2])
            2'b00: calMode = pef_pkg::PEF_CAL_1HZ;
            2'b01: calMode = pef_pkg::PEF_CAL_512HZ;
            2'b10: calMode = pef_pkg::PEF_CAL_500HZ;
            2'b11: calMode = pef_pkg::PEF_CAL_16KHZ;
        endcase
    end

    assign hitAddr = (sfrAddr == pef_pkg::ADDR_KEY) ||
                     (sfrAddr == pef_pkg::ADDR_POWER_CFG) ||
                     (sfrAddr == pef_pkg::ADDR_EVENT_ENABLE) ||
                     (sfrAddr == pef_pkg::ADDR_PERIPHERAL_CFG_CFG) ||
                     (sfrAddr == pef_pkg::ADDR_BATT_SWITCH) ||
                     (sfrAddr == pef_pkg::ADDR_EVENT_FLAGS) ||
                     (sfrAddr >= pef_pkg::ADDR_SCRATCH_ONE);

    // Peripheral status bits 6..5 reflect the live supply source
    assign rdMux =
        (sfrAddr == pef_pkg::ADDR_KEY)          ? unlockKey_r :
        (sfrAddr == pef_pkg::ADDR_POWER_CFG)    ? powerCfg_r :
        (sfrAddr == pef_pkg::ADDR_EVENT_ENABLE) ? eventEnable_r :
        (sfrAddr == pef_pkg::ADDR_PERIPHERAL_CFG_CFG)   ? (periphCfg_r | {1'b0, suppSync2_r,
                                                    suppSync2_r, 5'h00}) :
        (sfrAddr == pef_pkg::ADDR_BATT_SWITCH)  ? battSwitchCfg_r :
        (sfrAddr == pef_pkg::ADDR_EVENT_FLAGS)  ? flags :
        (sfrAddr == pef_pkg::ADDR_SCRATCH_ONE)  ? scratch_r[0] :
        (sfrAddr == pef_pkg::ADDR_SCRATCH_TWO)  ? scratch_r[1] :
        (sfrAddr == pef_pkg::ADDR_SCRATCH_THREE)? scratch_r[2] :
        (sfrAddr == pef_pkg::ADDR_SCRATCH_FOUR) ? scratch_r[3] :
        (sfrAddr == pef_pkg::ADDR_IRQ_PIN_CFG)  ? irqPinCfg_r : 8'h00;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sfrRdData          <= 8'h00;
            sfrHit             <= 1'b0;
            calOutSel          <= 4'h1;
            calWindowLong      <= 1'b1;
            extIrq1Enable      <= 1'b0;
            extIrq1GpioMode    <= 1'b1;
            batteryCtrlInputEn <= 1'b0;
            extIrq0Enable      <= 1'b0;
            eventFlagsOut      <= 8'h00;
            powerEventIrq      <= 1'b0;
        end else begin
            sfrRdData          <= sfrRdEn ? rdMux : 8'h00;
            sfrHit             <= (sfrRdEn | sfrWrEn) & hitAddr;
            calOutSel          <= calMode;
            calWindowLong      <= ~irqPinCfg_r[pef_pkg::CAL_SEL_LSB + 1];
            extIrq1Enable      <= irq1Fn[2] & irq1Fn[1];
            extIrq1GpioMode    <= ~irq1Fn[0];
            batteryCtrlInputEn <= irq1Fn[0];
            extIrq0Enable      <= irqPinCfg_r[pef_pkg::IRQ0_FN_BIT];
            eventFlagsOut      <= flags;
            powerEventIrq      <= summary_r;
        end
    end
endmodule

/* File: tb/pef_power_events_chk.sv */
// Port assertions for the power event flag block
`timescale 1ns/1ps
module pef_power_events_chk (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic       sfrWrEn,
    input wire logic       sagEvent,
    input wire logic       onMainSupply,
    input wire logic [3:0] calOutSel,
    input wire logic       calWindowLong,
    input wire logic       extIrq1GpioMode,
    input wire logic       batteryCtrlInputEn,
    input wire logic       extIrq0Enable,
    input wire logic [7:0] eventFlagsOut,
    input wire logic       powerEventIrq
);
    logic [7:0] keyShadow_r;
    logic [7:0] enShadow_r;
    logic       pinWr;
    assign pinWr = sfrWrEn && sfrAddr == pef_pkg::ADDR_IRQ_PIN_CFG;
    // Shadows track the key and enable registers from the write traffic alone
    always_ff @(posedge clk) begin
        if (!rstn) begin
            keyShadow_r <= 8'h00;
            enShadow_r  <= 8'h00;
        end else if (sfrWrEn && sfrAddr == pef_pkg::ADDR_KEY) begin
            keyShadow_r <= sfrWrData;
        end else if (sfrWrEn && sfrAddr == pef_pkg::ADDR_EVENT_ENABLE) begin
            enShadow_r  <= sfrWrData & 8'haf;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_cal; calWindowLong == (calOutSel[0] | calOutSel[1]); endproperty
    a_cal: assert property (p_cal) else $error("cal window mismatch");
    property p_locked; pinWr && keyShadow_r != 8'hea |=> $stable(extIrq0Enable) [*2]; endproperty
    a_locked: assert property (p_locked) else $error("locked write took");
    property p_open; pinWr && keyShadow_r == 8'hea |=> ##1 extIrq0Enable == $past(sfrWrData[0], 2);
    endproperty
    a_open: assert property (p_open) else $error("unlocked write lost");
    property p_mode; extIrq1GpioMode != batteryCtrlInputEn; endproperty
    a_mode: assert property (p_mode) else $error("irq1 mode clash");
    property p_irq; powerEventIrq == eventFlagsOut[6]; endproperty
    a_irq: assert property (p_irq) else $error("irq differs from summary");
    property p_sumSet; |(eventFlagsOut & enShadow_r) |=> eventFlagsOut[6]; endproperty
    a_sumSet: assert property (p_sumSet) else $error("summary not set");
    property p_sumCause; $rose(eventFlagsOut[6]) |-> |(eventFlagsOut & enShadow_r); endproperty
    a_sumCause: assert property (p_sumCause) else $error("summary without enabled flag");
    property p_sticky; |($past(eventFlagsOut) & ~eventFlagsOut & 8'haf)
        |-> $past(sfrWrEn && sfrAddr == pef_pkg::ADDR_EVENT_FLAGS, 2); endproperty
    a_sticky: assert property (p_sticky) else $error("flag fell without write");
    property p_sag; $rose(sagEvent) |-> ##[3:6] eventFlagsOut[5]; endproperty
    a_sag: assert property (p_sag) else $error("sag flag late");
    property p_swap; $fell(onMainSupply) |-> ##[4:8] eventFlagsOut[1]; endproperty
    a_swap: assert property (p_swap) else $error("switchover flag late");
    property p_rsv; !eventFlagsOut[4]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag set");
endmodule
bind pef_power_events pef_power_events_chk u_chk (.clk(clk), .rstn(rstn), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sagEvent(sagEvent), .onMainSupply(onMainSupply),
    .calOutSel(calOutSel), .calWindowLong(calWindowLong), .extIrq1GpioMode(extIrq1GpioMode),
    .batteryCtrlInputEn(batteryCtrlInputEn), .extIrq0Enable(extIrq0Enable),
    .eventFlagsOut(eventFlagsOut), .powerEventIrq(powerEventIrq));

/* File: tb/tb_top.sv */
// Self-checking bench for the power event flag block
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wrEn = 1'b0;
    logic       rdEn = 1'b0;
    logic       onMain = 1'b1;
    logic [5:0] evs = 6'h00;
    logic [7:0] rdData, flagsOut;
    logic [3:0] calSel;
    logic       hit, winLong, irq1En, irq1Gpio, bctrlEn, irq0En, psmIrq;
    int         mismatches = 0;
    int         nChecks = 0;
    int         cycles = 0;
    always #2 clk = ~clk;
    pef_power_events uut (.clk(clk), .rstn(rstn), .sfrAddr(addr), .sfrWrData(wdata),
        .sfrWrEn(wrEn), .sfrRdEn(rdEn), .onMainSupply(onMain), .sagEvent(evs[5]),
        .dcinDeltaEvent(evs[1]), .dcinReadyEvent(evs[2]), .battLowEvent(evs[3]),
        .battReadyEvent(evs[4]), .dcinLowEvent(evs[0]), .sfrRdData(rdData), .sfrHit(hit),
        .calOutSel(calSel), .calWindowLong(winLong), .extIrq1Enable(irq1En),
        .extIrq1GpioMode(irq1Gpio), .batteryCtrlInputEn(bctrlEn), .extIrq0Enable(irq0En),
        .eventFlagsOut(flagsOut), .powerEventIrq(psmIrq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    // Read data stands for one cycle only, so it is sampled just after the answer edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic expHit);
        @(posedge clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        chk(rdData, exp);
        chk({7'h00, hit}, {7'h00, expHit});
    endtask
    task automatic t_regs();
        logic [7:0] ad [8] = '{8'hc5, 8'hec, 8'hf4, 8'hf5, 8'hfb, 8'hfc, 8'hfd, 8'hfe};
        logic [7:0] wv [8] = '{8'hff, 8'haf, 8'h6b, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff};
        chk({calSel, winLong, irq1Gpio, 2'b00}, 8'h1c);
        for (int i = 0; i < 8; i++) begin
            rd(ad[i], (i == 2) ? 8'h60 : 8'h00, 1'b1);
            wr(ad[i], 8'hff);
            rd(ad[i], wv[i], 1'b1);
            wr(ad[i], 8'h00);
        end
        rd(8'h00, 8'h00, 1'b0);
        rd(pef_pkg::ADDR_EVENT_FLAGS, 8'h00, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_pins();
        logic [7:0] d;
        wr(pef_pkg::ADDR_IRQ_PIN_CFG, 8'hff);
        rd(pef_pkg::ADDR_IRQ_PIN_CFG, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            d = {1'b1, i[1:0], 1'b1, i[1], i[1], i[0], i[0]};
            wr(pef_pkg::ADDR_KEY, pef_pkg::UNLOCK_KEY);
            wr(pef_pkg::ADDR_IRQ_PIN_CFG, d);
            wr(pef_pkg::ADDR_KEY, 8'h00);
            wr(pef_pkg::ADDR_IRQ_PIN_CFG, 8'h00);
            rd(pef_pkg::ADDR_IRQ_PIN_CFG, d & pef_pkg::PIN_CFG_MASK, 1'b1);
            chk({calSel, winLong, irq1En, irq1Gpio, bctrlEn},
                {4'b0001 << i, i < 2, i[1], !i[0], i[0]});
            chk({7'h00, irq0En}, {7'h00, i[0]});
        end
        $display("test pins done");
    endtask
    task automatic t_events();
        int         bitOf [8] = '{0, 3, 3, 2, 2, 5, 1, 7};
        logic [7:0] e;
        wr(pef_pkg::ADDR_EVENT_ENABLE, 8'h2f);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            if (k < 6) evs[k] <= 1'b1;
            else onMain <= (k == 7);
            repeat (3) @(posedge clk);
            evs <= 6'h00;
            repeat (12) @(posedge clk);
            // Supply restored is left disabled, so it must not raise the summary
            e = (8'h01 << bitOf[k]) | ((k == 7) ? 8'h00 : 8'h40);
            rd(pef_pkg::ADDR_EVENT_FLAGS, e, 1'b1);
            chk({flagsOut[7:1], psmIrq}, {e[7:1], e[6]});
            wr(pef_pkg::ADDR_EVENT_FLAGS, 8'hef);
            rd(pef_pkg::ADDR_EVENT_FLAGS, e, 1'b1);
            wr(pef_pkg::ADDR_EVENT_FLAGS, 8'h00);
            wr(pef_pkg::ADDR_EVENT_FLAGS, 8'h00);
            rd(pef_pkg::ADDR_EVENT_FLAGS, 8'h00, 1'b1);
        end
        $display("test events done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_pins();
        t_events();
        summarize();
    end
    // All tests need well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
endmodule
